// >>> design/rcc_buf_mem.v
// Purpose: byte memory for the four level-2 buffers
// Assumes: one write port and one read port on the same clock
// Notes: read data come out of a register one cycle after the address
`timescale 1ns/1ps
`default_nettype none
module rcc_buf_mem
(
  input  wire       clk_i,
  input  wire       wr_en_i,
  input  wire [8:0] wr_addr_i,
  input  wire [7:0] wr_data_i,
  input  wire [8:0] rd_addr_i,
  output reg  [7:0] rd_data_o
);
  reg [7:0] mem_q [0:511];

  // write and registered read
  always @(posedge clk_i)
  begin
    if (wr_en_i)
      mem_q[wr_addr_i] <= wr_data_i;
    rd_data_o <= mem_q[rd_addr_i];
  end
endmodule
`default_nettype wire

// >>> design/rcc_control.v
// Purpose: register bank, keepalive, level-1 accept capture and buffer readout
// Assumes: one clock clk_i at 125 MHz standing in for the fast phase and shift clocks
// Notes: pins from other domains pass two flip-flops before use
`timescale 1ns/1ps
`default_nettype none
`include "rcc_regs.vh"
module rcc_control
(
  input  wire        clk_i,
  input  wire        reset_n_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_data_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [7:0]  reg_data_o,
  output reg         reg_data_oe_o,
  input  wire [15:0] board_serial_i,
  input  wire        level1_accept_input_i,
  input  wire        slow_bunch_clock_i,
  input  wire        bunch_zero_crossing_i,
  input  wire        word_frame_marker_i,
  input  wire        buffer_clear_i,
  input  wire [7:0]  hit_byte_i,
  output reg         keepalive_o,
  output reg         data_out_oe_o,
  output reg         test_pattern_o,
  output reg         prog_regs_o,
  output reg  [7:0]  tb_reprog_o,
  output reg         uncertain_window_gate_o,
  output reg  [1:0]  accept_buf_o,
  output reg         accept_taken_o,
  output reg         accept_refused_o,
  output reg         aligned_slow_clock_o,
  output reg         delayed_zero_marker_o,
  output reg  [2:0]  window_edge_o
);
  localparam ST_IDLE = 2'b00;
  localparam ST_HEAD = 2'b01;
  localparam ST_DATA = 2'b10;

  // two-flop synchronisers for the serial, accept, slow clock, zero crossing and frame pins
  reg [19:0] sync1_q;
  reg [19:0] sync2_q;
  wire [19:0] pins = {board_serial_i, level1_accept_input_i, slow_bunch_clock_i,
                      bunch_zero_crossing_i, word_frame_marker_i};
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      sync1_q <= 20'h00000;
      sync2_q <= 20'h00000;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end
  wire [15:0] serial_s = sync2_q[19:4];
  wire        l1a_s    = sync2_q[3];
  wire        slow_s   = sync2_q[2];
  wire        zero_s   = sync2_q[1];
  wire        frame_s  = sync2_q[0];

  // register bank
  reg  [1:0] buf_sel_q;
  reg  [6:0] byte_addr_q;
  reg  [7:0] read_byte_q;
  reg  [7:0] tbin_q;
  reg  [7:0] ka_en_q;
  reg  [7:0] uw_en_q;
  reg  [5:0] content_q [0:3];
  reg        fetch_q;
  reg        fetch2_q;
  reg        init_done_q;
  wire       wr_addr_hit = reg_wr_i && (reg_addr_i == `RCC_OFS_BYTE_ADDR);
  wire       rd_byte_hit = reg_rd_i && (reg_addr_i == `RCC_OFS_READ_BYTE);

  // next byte address in the column-wise readout order
  reg [6:0] next_addr;
  always @*
  begin
    if (byte_addr_q == 7'd0)
      next_addr = 7'd1;
    else if (byte_addr_q == `RCC_DATA_BYTES)
      next_addr = 7'd0;
    else if (byte_addr_q >= `RCC_LAST_ROW_START)
      next_addr = byte_addr_q - (`RCC_LAST_ROW_START - 7'd2);
    else
      next_addr = byte_addr_q + `RCC_ROW_BYTES;
  end

  // host writes; version addresses have no storage so writes fall away
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      buf_sel_q               <= 2'b00;
      byte_addr_q             <= 7'd0;
      tbin_q                  <= `RCC_TBIN_RST;
      tb_reprog_o             <= 8'h00;
      ka_en_q                 <= `RCC_KA_ENABLE_RST;
      uw_en_q                 <= 8'h00;
      uncertain_window_gate_o <= 1'b0;
      prog_regs_o             <= 1'b0;
      init_done_q             <= 1'b0;
      fetch_q                 <= 1'b0;
      fetch2_q                <= 1'b0;
    end
    else
    begin
      init_done_q <= 1'b1;
      // strobe once after initialisation and on programming writes only
      prog_regs_o <= !init_done_q ||
                     (reg_wr_i && (reg_addr_i == `RCC_OFS_KA_ENABLE)) ||
                     (reg_wr_i && (reg_addr_i == `RCC_OFS_UW_ENABLE) &&
                      reg_data_i[`RCC_SHARED_BIT]);
      fetch_q  <= wr_addr_hit || rd_byte_hit;
      fetch2_q <= fetch_q;  // memory sees the new address one edge after the update
      if (wr_addr_hit)
        byte_addr_q <= reg_data_i[6:0];
      else if (rd_byte_hit)
        byte_addr_q <= next_addr;
      if (reg_wr_i)
      begin
        case (reg_addr_i)
          `RCC_OFS_BUF_SEL:    buf_sel_q   <= reg_data_i[1:0];
          `RCC_OFS_TBIN_COUNT: tbin_q      <= reg_data_i;
          `RCC_OFS_TB_REPROG:  tb_reprog_o <= reg_data_i;
          `RCC_OFS_KA_ENABLE:  ka_en_q     <= reg_data_i;
          `RCC_OFS_UW_ENABLE:
          begin
            uw_en_q                 <= reg_data_i;
            uncertain_window_gate_o <= reg_data_i[`RCC_SHARED_BIT];
          end
          default: ;  // version, serial and content offsets ignore writes
        endcase
      end
    end
  end

  // fetched byte lands two cycles after the address update, once the memory has read it
  wire [7:0] mem_rd_data;
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
      read_byte_q <= 8'h00;
    else if (fetch2_q)
      read_byte_q <= mem_rd_data;
  end

  // read mux; data driven one cycle after the strobe
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      reg_data_o    <= 8'h00;
      reg_data_oe_o <= 1'b0;
    end
    else
    begin
      reg_data_oe_o <= reg_rd_i;
      case (reg_addr_i)
        `RCC_OFS_BUF_SEL:         reg_data_o <= {6'h00, buf_sel_q};
        `RCC_OFS_BYTE_ADDR:       reg_data_o <= {1'b0, byte_addr_q};
        `RCC_OFS_READ_BYTE:       reg_data_o <= read_byte_q;
        `RCC_OFS_CONTENT0:        reg_data_o <= {2'b00, content_q[0]};
        `RCC_OFS_CONTENT0 + 8'h04: reg_data_o <= {2'b00, content_q[1]};
        `RCC_OFS_CONTENT0 + 8'h08: reg_data_o <= {2'b00, content_q[2]};
        `RCC_OFS_CONTENT0 + 8'h0C: reg_data_o <= {2'b00, content_q[3]};
        `RCC_OFS_CTRL_VER:        reg_data_o <= `RCC_CTRL_VER;
        `RCC_OFS_DATA_VER:        reg_data_o <= `RCC_DATA_VER;
        `RCC_OFS_PROG_VER:        reg_data_o <= `RCC_PROG_VER;
        `RCC_OFS_SERIAL_LO:       reg_data_o <= serial_s[7:0];
        `RCC_OFS_SERIAL_HI:       reg_data_o <= serial_s[15:8];
        `RCC_OFS_TBIN_COUNT:      reg_data_o <= tbin_q;
        `RCC_OFS_TB_REPROG:       reg_data_o <= tb_reprog_o;
        `RCC_OFS_KA_ENABLE:       reg_data_o <= ka_en_q;
        `RCC_OFS_UW_ENABLE:       reg_data_o <= uw_en_q;
        default:                  reg_data_o <= 8'h00;
      endcase
    end
  end

  // keepalive every 16 shift cycles while enabled, watchdog of 64
  reg [4:0] ka_cnt_q;
  reg [6:0] wd_cnt_q;
  reg       frame_d_q;
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      ka_cnt_q       <= 5'd0;
      wd_cnt_q       <= 7'd0;
      keepalive_o    <= 1'b0;
      data_out_oe_o  <= 1'b0;
      test_pattern_o <= 1'b0;
      frame_d_q      <= 1'b0;
    end
    else
    begin
      frame_d_q <= frame_s;
      ka_cnt_q  <= (ka_cnt_q == `RCC_KA_PERIOD - 5'd1) ? 5'd0 : ka_cnt_q + 5'd1;
      keepalive_o <= ka_en_q[0] && (ka_cnt_q == 5'd0);
      if (keepalive_o)
        wd_cnt_q <= 7'd0;
      else if (wd_cnt_q != `RCC_KA_TIMEOUT)
        wd_cnt_q <= wd_cnt_q + 7'd1;
      data_out_oe_o <= keepalive_o || (wd_cnt_q < `RCC_KA_TIMEOUT - 7'd1);
      if (ka_en_q[0])
        test_pattern_o <= 1'b0;
      else if (frame_s && !frame_d_q)
        test_pattern_o <= !test_pattern_o;
    end
  end

  // slow clock delay line, bunch counter and stretched zero marker
  reg [`RCC_SLOW_DELAY-1:0]   slow_dly_q;
  reg [`RCC_ZERO_STRETCH-1:0] zero_sr_q;
  reg                         aligned_d_q;
  reg [7:0]                   bunch_cnt_q;
  reg [2:0]                   bin_q;
  wire aligned_rise = aligned_slow_clock_o && !aligned_d_q;
  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      slow_dly_q            <= {`RCC_SLOW_DELAY{1'b0}};
      zero_sr_q             <= {`RCC_ZERO_STRETCH{1'b0}};
      aligned_slow_clock_o  <= 1'b0;
      aligned_d_q           <= 1'b0;
      delayed_zero_marker_o <= 1'b0;
      bunch_cnt_q           <= 8'h00;
      bin_q                 <= 3'd0;
      window_edge_o         <= 3'b000;
    end
    else
    begin
      slow_dly_q           <= {slow_dly_q[`RCC_SLOW_DELAY-2:0], slow_s};
      aligned_slow_clock_o <= slow_dly_q[`RCC_SLOW_DELAY-1];
      aligned_d_q          <= aligned_slow_clock_o;
      zero_sr_q            <= {zero_sr_q[`RCC_ZERO_STRETCH-2:0], zero_s};
      delayed_zero_marker_o <= |zero_sr_q;
      if (zero_s)
        bunch_cnt_q <= 8'h00;
      else if (aligned_rise)
        bunch_cnt_q <= bunch_cnt_q + 8'h01;
      bin_q         <= aligned_rise ? 3'd0 : bin_q + 3'd1;
      window_edge_o <= bin_q ^ (bin_q >> 1);
    end
  end

  // level-1 accept capture machine
  reg [1:0] state_q;
  reg       l1a_d_q;
  reg [3:0] filled_q;
  reg [1:0] wr_buf_q;
  reg [6:0] wr_byte_q;
  reg [3:0] col_q;
  reg       mem_we;
  reg [7:0] mem_wd;
  wire      l1a_rise = l1a_s && !l1a_d_q;
  always @*
  begin
    mem_we = 1'b0;
    mem_wd = hit_byte_i;
    case (state_q)
      ST_HEAD:
      begin
        mem_we = 1'b1;
        mem_wd = bunch_cnt_q;
      end
      ST_DATA: mem_we = 1'b1;
      default: mem_we = 1'b0;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q          <= ST_IDLE;
      l1a_d_q          <= 1'b0;
      filled_q         <= 4'h0;
      wr_buf_q         <= 2'b00;
      wr_byte_q        <= 7'd0;
      col_q            <= 4'd0;
      accept_buf_o     <= 2'b00;
      accept_taken_o   <= 1'b0;
      accept_refused_o <= 1'b0;
      content_q[0]     <= 6'h00;
      content_q[1]     <= 6'h00;
      content_q[2]     <= 6'h00;
      content_q[3]     <= 6'h00;
    end
    else
    begin
      l1a_d_q          <= l1a_s;
      accept_taken_o   <= 1'b0;
      accept_refused_o <= 1'b0;
      if (buffer_clear_i)
        filled_q <= 4'h0;
      case (state_q)
        ST_IDLE:
        begin
          if (l1a_rise && (buffer_clear_i || !filled_q[wr_buf_q]))
          begin
            accept_buf_o   <= wr_buf_q;
            accept_taken_o <= 1'b1;
            content_q[wr_buf_q] <= 6'h00;
            wr_byte_q      <= 7'd0;
            state_q        <= ST_HEAD;
          end
          else if (l1a_rise)
            accept_refused_o <= 1'b1;
        end
        ST_HEAD:
        begin
          wr_byte_q <= 7'd1;
          col_q     <= 4'd0;
          state_q   <= ST_DATA;
        end
        ST_DATA:
        begin
          if (hit_byte_i != 8'h00)
            content_q[wr_buf_q][col_q[3:1]] <= 1'b1;
          col_q     <= (col_q == 4'd11) ? 4'd0 : col_q + 4'd1;
          wr_byte_q <= wr_byte_q + 7'd1;
          if (wr_byte_q == `RCC_DATA_BYTES)
          begin
            filled_q[wr_buf_q] <= 1'b1;
            wr_buf_q <= wr_buf_q + 2'b01;
            state_q  <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // level-2 buffer storage, 128 byte slots per buffer
  rcc_buf_mem u_mem
  (
    .clk_i     (clk_i),
    .wr_en_i   (mem_we),
    .wr_addr_i ({wr_buf_q, wr_byte_q}),
    .wr_data_i (mem_wd),
    .rd_addr_i ({buf_sel_q, byte_addr_q}),
    .rd_data_o (mem_rd_data)
  );
endmodule
`default_nettype wire

// >>> design/rcc_regs.vh
// Purpose: offsets, reset values and timing counts of the readout card control logic
// Assumes: included by bare name from the design files
// Notes: offsets are the byte offsets seen on the register port
// Contract
// - read-only version registers for controller, data and programmer designs
// - each version reads a nonzero number, starting at one
// - both gate-array versions are held in this controller logic
// - data outputs float unless keepalive was seen within 64 shift cycles
// - buffer byte 0 holds bunch count, bytes 1 to 72 hold hit data
// - byte address advances automatically after each buffer byte read
// - keepalive enable register comes up all ones
// - writing keepalive enable fires the board programming strobe
// - keepalive disabled gives alternating test pattern per word frame period
// - programming strobe only on writes needing it, and once after initialisation
// - window edge signals step as a gray count, one bit per step
// - level-1 accept is active high, rising edge found by a register stage
// - accepts aimed at a filled buffer are refused; accepted address recorded
// - buffer clear lets any buffer be written regardless of its status
// - slow bunch clock delayed by fast cycles before driving buffer storage
// - four read-only content registers flag channel groups holding nonzero data
// - delayed bunch-zero marker made by shift register, three times as wide
// - registers for time bin count and transition board reprogram signal
// - uncertain window enable register; data bit 7 shared with programming
// - two serial number registers report the card identity
// - writing byte address fetches that byte into the read-byte register
`ifndef RCC_REGS_VH
`define RCC_REGS_VH
`define RCC_OFS_BUF_SEL      8'h34
`define RCC_OFS_BYTE_ADDR    8'h38
`define RCC_OFS_READ_BYTE    8'h3C
`define RCC_OFS_CONTENT0     8'h40
`define RCC_OFS_CTRL_VER     8'h50
`define RCC_OFS_DATA_VER     8'h54
`define RCC_OFS_SERIAL_LO    8'h6C
`define RCC_OFS_SERIAL_HI    8'h70
`define RCC_OFS_TBIN_COUNT   8'h74
`define RCC_OFS_TB_REPROG    8'h78
`define RCC_OFS_KA_ENABLE    8'h7C
`define RCC_OFS_UW_ENABLE    8'h80
`define RCC_OFS_PROG_VER     8'hE0
// version numbers, arbitrary nonzero values
`define RCC_CTRL_VER         8'h01
`define RCC_DATA_VER         8'h01
`define RCC_PROG_VER         8'h01
`define RCC_KA_ENABLE_RST    8'hFF
`define RCC_TBIN_RST         8'h06
`define RCC_SHARED_BIT       7
`define RCC_KA_PERIOD        5'd16
`define RCC_KA_TIMEOUT       7'd64
`define RCC_DATA_BYTES       7'd72
`define RCC_ROW_BYTES        7'd12
`define RCC_LAST_ROW_START   7'd61
`define RCC_SLOW_DELAY       8
`define RCC_ZERO_STRETCH     3
`endif

// >>> tb/rcc_control_assertions.sv
// Purpose: port-level checks of the readout card control block
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every rcc_control instance
`timescale 1ns/1ps
`default_nettype none
`include "rcc_regs.vh"
module rcc_control_checker
(
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_data_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_data_o,
  input wire logic       reg_data_oe_o,
  input wire logic       slow_bunch_clock_i,
  input wire logic       keepalive_o,
  input wire logic       data_out_oe_o,
  input wire logic       prog_regs_o,
  input wire logic [7:0] tb_reprog_o,
  input wire logic       uncertain_window_gate_o,
  input wire logic       accept_taken_o,
  input wire logic       accept_refused_o,
  input wire logic       aligned_slow_clock_o,
  input wire logic [2:0] window_edge_o
);
  logic [7:0] idle_q;
  logic [7:0] idle_d;
  // quiet keepalive cycles, saturating
  always_comb idle_d = keepalive_o ? 8'h00 : (idle_q == 8'hFF ? idle_q : idle_q + 8'h01);
  always_ff @(posedge clk_i) idle_q <= reset_n_i ? idle_d : 8'h00;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_read_drive: assert property (reg_data_oe_o == $past(reg_rd_i))
    else $error("read got no drive enable");
  chk_ver_value: assert property (reg_rd_i && reg_addr_i == 8'h54 |=>
    reg_data_o == `RCC_DATA_VER && reg_data_o != 8'h00) else $error("bad data version");
  chk_ka_gap: assert property (keepalive_o |=> !keepalive_o [*8])
    else $error("keepalive pulses too close");
  chk_float_late: assert property (idle_q > 8'd63 |-> !data_out_oe_o)
    else $error("outputs still enabled without keepalive");
  chk_prog_write: assert property (reg_wr_i && reg_addr_i == 8'h7C |=> prog_regs_o)
    else $error("no programming strobe");
  chk_prog_cause: assert property (prog_regs_o |-> $past(!reset_n_i, 2) ||
    $past(reg_wr_i) && ($past(reg_addr_i) == 8'h7C ||
    $past(reg_addr_i) == 8'h80 && $past(reg_data_i[7])))
    else $error("programming strobe without cause");
  chk_one_take: assert property (accept_taken_o |=> !accept_taken_o [*8] ##0 !accept_refused_o)
    else $error("accept taken during capture");
  chk_gray_step: assert property ($countones(window_edge_o ^ $past(window_edge_o)) <= 1)
    else $error("window edge changed two bits");
  chk_slow_align: assert property (aligned_slow_clock_o == $past(slow_bunch_clock_i, 11))
    else $error("aligned slow clock off");
  chk_gate_bit: assert property (reg_wr_i && reg_addr_i == 8'h80 |=>
    uncertain_window_gate_o == $past(reg_data_i[7])) else $error("gate bit wrong");
  chk_reprog_val: assert property (reg_wr_i && reg_addr_i == 8'h78 |=>
    tb_reprog_o == $past(reg_data_i)) else $error("reprogram value wrong");
endmodule
bind rcc_control rcc_control_checker rcc_control_checker_i (.clk_i, .reset_n_i, .reg_addr_i,
  .reg_data_i, .reg_wr_i, .reg_rd_i, .reg_data_o, .reg_data_oe_o, .slow_bunch_clock_i,
  .keepalive_o, .data_out_oe_o, .prog_regs_o, .tb_reprog_o, .uncertain_window_gate_o,
  .accept_taken_o, .accept_refused_o, .aligned_slow_clock_o, .window_edge_o);
`default_nettype wire

// >>> tb/rcc_control_bench.sv
// Purpose: register, accept and keepalive tests of the control block
// Assumes: inputs change on the falling edge
// Notes: hit data held constant so buffer contents are known
`timescale 1ns/1ps
`default_nettype none
`include "rcc_regs.vh"
module rcc_control_bench;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_data_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [15:0] board_serial_i = 16'hA5C3;
  logic level1_accept_input_i = 1'b0;
  logic bunch_zero_crossing_i = 1'b0;
  logic buffer_clear_i = 1'b0;
  logic [7:0] hit_byte_i = 8'h3C;
  wire logic [7:0] reg_data_o, tb_reprog_o;
  wire logic [2:0] window_edge_o;
  wire logic [1:0] accept_buf_o;
  wire logic reg_data_oe_o, keepalive_o, data_out_oe_o, test_pattern_o, prog_regs_o;
  wire logic uncertain_window_gate_o, accept_taken_o, accept_refused_o, aligned_slow_clock_o;
  wire logic delayed_zero_marker_o, word_frame_marker_i, slow_bunch_clock_i, outputs_float;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int hi = 0;
  logic tk, rf, t0;
  logic [7:0] va [3] = '{8'h50, 8'h54, 8'hE0};
  logic [7:0] ve [3] = '{`RCC_CTRL_VER, `RCC_DATA_VER, `RCC_PROG_VER};
  rcc_control rcc_control_i (.clk_i, .reset_n_i, .reg_addr_i, .reg_data_i, .reg_wr_i, .reg_rd_i,
    .reg_data_o, .reg_data_oe_o, .board_serial_i, .level1_accept_input_i, .slow_bunch_clock_i,
    .bunch_zero_crossing_i, .word_frame_marker_i, .buffer_clear_i, .hit_byte_i, .keepalive_o,
    .data_out_oe_o, .test_pattern_o, .prog_regs_o, .tb_reprog_o, .uncertain_window_gate_o,
    .accept_buf_o, .accept_taken_o, .accept_refused_o, .aligned_slow_clock_o,
    .delayed_zero_marker_o, .window_edge_o);
  rcc_far_model rcc_far_model_i (.keepalive_i(keepalive_o), .clk_i, .reset_n_i,
    .word_frame_marker_o(word_frame_marker_i), .slow_bunch_clock_o(slow_bunch_clock_i),
    .outputs_float_o(outputs_float));
  // 125 MHz clock and run limit
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_data_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
    check(what, reg_data_o, exp);
  endtask
  // pulse the accept pin and note which answer came back
  task automatic accept();
    tk = 1'b0;
    rf = 1'b0;
    level1_accept_input_i = 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge clk_i);
      tk |= accept_taken_o === 1'b1;
      rf |= accept_refused_o === 1'b1;
      if (i == 4) level1_accept_input_i = 1'b0;
    end
    repeat (80) @(negedge clk_i);
  endtask
  initial
  begin
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      rdc("version", va[k], ve[k]);
      wr(va[k], 8'h55);
      rdc("version_after_write", va[k], ve[k]);
    end
    rdc("serial_low", 8'h6C, 8'hC3);
    rdc("serial_high", 8'h70, 8'hA5);
    rdc("ka_enable_reset", 8'h7C, 8'hFF);
    rdc("time_bins_reset", 8'h74, `RCC_TBIN_RST);
    wr(8'h74, 8'h09);
    rdc("time_bins", 8'h74, 8'h09);
    wr(8'h78, 8'h5A);
    rdc("reprogram", 8'h78, 8'h5A);
    check("reprogram_pin", tb_reprog_o, 8'h5A);
    rdc("unmapped", 8'h90, 8'h00);
    wr(8'h80, 8'h80);
    check("window_gate", {7'h00, uncertain_window_gate_o}, 8'h01);
    wr(8'h80, 8'h00);
    check("window_gate_off", {7'h00, uncertain_window_gate_o}, 8'h00);
    bunch_zero_crossing_i = 1'b1;
    @(negedge clk_i);
    bunch_zero_crossing_i = 1'b0;
    hi = 0;
    for (int i = 0; i < 30; i++)
    begin
      @(negedge clk_i);
      hi += delayed_zero_marker_o === 1'b1;
    end
    check("marker_width", 8'(hi), 8'h03);
    for (int b = 0; b < 5; b++)
    begin
      accept();
      check("accept_taken", {7'h00, tk}, b < 4 ? 8'h01 : 8'h00);
      check("accept_refused", {7'h00, rf}, b < 4 ? 8'h00 : 8'h01);
      if (b < 4) check("accept_buf", {6'h00, accept_buf_o}, 8'(b));
    end
    wr(8'h34, 8'h00);
    rdc("content_flags", 8'h40, 8'h3F);
    wr(8'h38, 8'h01);
    repeat (3) @(negedge clk_i);
    rdc("read_byte", 8'h3C, 8'h3C);
    rdc("next_address", 8'h38, 8'h0D);
    buffer_clear_i = 1'b1;
    repeat (2) @(negedge clk_i);
    buffer_clear_i = 1'b0;
    accept();
    check("accept_after_clear", {7'h00, tk}, 8'h01);
    wr(8'h7C, 8'h00);
    repeat (100) @(negedge clk_i);
    check("outputs_enabled_off", {7'h00, data_out_oe_o}, 8'h00);
    check("far_side_float", {7'h00, outputs_float}, 8'h01);
    t0 = test_pattern_o;
    repeat (40) @(negedge clk_i);
    check("test_pattern", {7'h00, test_pattern_o}, {7'h00, ~t0});
    wr(8'h7C, 8'hFF);
    repeat (100) @(negedge clk_i);
    check("outputs_enabled_on", {7'h00, data_out_oe_o}, 8'h01);
    check("far_side_driven", {7'h00, outputs_float}, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire

// >>> tb/rcc_far_model.sv
// Purpose: data gate array side: keepalive watch, frame marker and slow clock
// Assumes: drives on the falling edge
// Notes: frame period 40 cycles, slow clock high 8 cycles twice per frame, rising edges 16 and 24 cycles apart
`timescale 1ns/1ps
`default_nettype none
module rcc_far_model
(
  input  wire logic keepalive_i,
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  output var  logic word_frame_marker_o,
  output var  logic slow_bunch_clock_o,
  output var  logic outputs_float_o
);
  logic [7:0] idle_q;
  logic [5:0] phase_q;
  // float after 64 shift cycles with no keepalive; expects one per 16
  always @(negedge clk_i)
  begin
    idle_q <= (!reset_n_i || keepalive_i) ? 8'h00 : (idle_q == 8'hFF ? idle_q : idle_q + 8'h01);
    outputs_float_o <= reset_n_i && idle_q >= 8'd64;
    phase_q <= (!reset_n_i || phase_q == 6'd39) ? 6'h00 : phase_q + 6'h01;
    word_frame_marker_o <= reset_n_i && phase_q < 6'd2;
    slow_bunch_clock_o <= reset_n_i && phase_q[3];
  end
endmodule
`default_nettype wire
